// ===== hw/sideband_ctrl.v
// Chosen here: the APB slave port and the register addresses.
`include "sideband_defines.vh"

module sideband_ctrl #(
  parameter IDENTITY_PORT_OPTION = 1,
  parameter MSI_VECTORS = 8,
  // Identity defaults; values arbitrary
  parameter [15:0] DEF_MAKER = 16'h0000,
  parameter [15:0] DEF_PART = 16'h0000,
  parameter [7:0] DEF_REVISION = 8'h00,
  parameter [23:0] DEF_CLASS = 24'h000000,
  parameter [15:0] DEF_SUB_MAKER = 16'h0000,
  parameter [15:0] DEF_SUB_PART = 16'h0000
) (
  // System
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  output reg irq_o,
  // Interrupt requests from user
  input wire [MSI_VECTORS-1:0] msi_req_i,
  input wire legacy_int_n_i,
  // Message TLP request toward transmit path
  output reg tlp_req_o,
  output reg [1:0] tlp_kind_o,
  output reg [31:0] tlp_addr_o,
  output reg [15:0] tlp_data_o,
  input wire tlp_ack_i,
  // Configuration request and completion
  input wire cfg_req_i,
  output reg cfg_cpl_valid_o,
  output reg cfg_cpl_retry_o,
  // Function reset
  input wire flr_rdy_i,
  output reg initiate_flr_o,
  // Mirrored configuration bits
  output reg [5:0] cmd_reg_o,
  output reg [4:0] dev_ctrl2_o,
  output reg [2:0] multi_msg_grant_o,
  output reg msi_enabled_o,
  output reg pme_allowed_o,
  output reg [1:0] pwr_state_out_o,
  // Power event
  input wire pme_event_i,
  // Identity loading
  input wire identity_load_strobe_i,
  input wire [15:0] maker_code_in_i,
  input wire [15:0] part_code_in_i,
  input wire [7:0] revision_code_in_i,
  input wire [23:0] class_code_in_i,
  input wire [15:0] subsystem_maker_code_in_i,
  input wire [15:0] subsystem_part_code_in_i,
  output reg [15:0] maker_code_o,
  output reg [15:0] part_code_o,
  output reg [7:0] revision_code_o,
  output reg [23:0] class_code_o,
  output reg [15:0] subsystem_maker_code_o,
  output reg [15:0] subsystem_part_code_o
);
  localparam IW = 3;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;

  reg [1:0] state;
  reg [31:0] msi_addr;
  reg [15:0] msi_data;
  reg pme_status;
  reg int_status;
  reg intx_want;
  reg intx_sent;
  reg [MSI_VECTORS-1:0] msi_pend;
  reg [MSI_VECTORS-1:0] msi_clr;
  reg [`EV_WIDTH-1:0] irq_status;
  reg [`EV_WIDTH-1:0] irq_enable;
  reg [`EV_WIDTH-1:0] ev;
  reg [`EV_WIDTH-1:0] next_irq_status;
  reg [MSI_VECTORS-1:0] next_msi_pend;
  reg [31:0] rd_mux;
  reg hit;
  reg [15:0] vec_mask;

  wire [MSI_VECTORS-1:0] msi_s;
  wire [MSI_VECTORS-1:0] msi_rise;
  wire [3:0] misc_s;
  wire [3:0] misc_rise;
  wire [3:0] misc_fall;
  wire [MSI_VECTORS-1:0] pick_hot;
  wire [IW-1:0] pick_idx;
  wire id_loaded;
  wire setup;
  wire wr_en;
  wire flr_go;

  edge_detect #(.W(MSI_VECTORS), .RST_VAL({MSI_VECTORS{1'b0}})) u_msi_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(msi_req_i),
    .q_o(msi_s),
    .rise_o(msi_rise),
    .fall_o()
  );

  // Legacy request idles high, so its sample resets high
  edge_detect #(.W(4), .RST_VAL(`MISC_RST_VAL)) u_misc_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({legacy_int_n_i, identity_load_strobe_i, flr_rdy_i, pme_event_i}),
    .q_o(misc_s),
    .rise_o(misc_rise),
    .fall_o(misc_fall)
  );

  prio_pick #(.N(MSI_VECTORS), .IW(IW)) u_pick (
    .req_i(msi_pend),
    .onehot_o(pick_hot),
    .idx_o(pick_idx)
  );

  // Without the option the identity inputs are ignored and requests always succeed
  assign id_loaded = (IDENTITY_PORT_OPTION != 0) ? misc_s[`MISC_IDLOAD] : 1'b1;
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
  assign flr_go = initiate_flr_o & misc_s[`MISC_FLR_RDY];

  // Low grant bits of message data carry the vector number
  always @* begin
    case (multi_msg_grant_o)
      3'h0: vec_mask = 16'h0000;
      3'h1: vec_mask = 16'h0001;
      3'h2: vec_mask = 16'h0003;
      3'h3: vec_mask = 16'h0007;
      default: vec_mask = 16'h0007;
    endcase
  end

  // Register read decode
  always @* begin
    rd_mux = 32'h00000000;
    hit = 1'b1;
    case (paddr_i)
      `OFF_CMD: rd_mux[5:0] = cmd_reg_o;
      `OFF_DEVCTL2: rd_mux[4:0] = dev_ctrl2_o;
      `OFF_MSI_CTRL: rd_mux[3:0] = {multi_msg_grant_o, msi_enabled_o};
      `OFF_MSI_ADDR: rd_mux = msi_addr;
      `OFF_MSI_DATA: rd_mux[15:0] = msi_data;
      `OFF_PM: rd_mux[3:0] = {pme_status, pme_allowed_o, pwr_state_out_o};
      `OFF_FLR: rd_mux[1:0] = {misc_s[`MISC_FLR_RDY], initiate_flr_o};
      `OFF_ID0: rd_mux = {part_code_o, maker_code_o};
      `OFF_ID1: rd_mux = {class_code_o, revision_code_o};
      `OFF_ID2: rd_mux = {subsystem_part_code_o, subsystem_maker_code_o};
      `OFF_SIDE_STAT: rd_mux[1:0] = {id_loaded, int_status};
      `OFF_IRQ_STATUS: rd_mux[`EV_WIDTH-1:0] = irq_status;
      `OFF_IRQ_CLEAR: rd_mux = 32'h00000000;
      `OFF_IRQ_ENABLE: rd_mux[`EV_WIDTH-1:0] = irq_enable;
      default: hit = 1'b0;
    endcase
  end

  // Events and sticky status; a set in the clearing cycle survives
  always @* begin
    ev = {`EV_WIDTH{1'b0}};
    ev[`EV_MSI_SENT] = (state == ST_SEND) & tlp_ack_i & (tlp_kind_o == `KIND_MWR);
    ev[`EV_INTX_SENT] = (state == ST_SEND) & tlp_ack_i & (tlp_kind_o != `KIND_MWR);
    ev[`EV_PME] = misc_rise[`MISC_PME];
    ev[`EV_FLR_DONE] = flr_go;
    ev[`EV_ID_LOADED] = misc_rise[`MISC_IDLOAD] & (IDENTITY_PORT_OPTION != 0);
    ev[`EV_RETRY] = cfg_req_i & ~id_loaded;
    next_irq_status = irq_status;
    if (wr_en && paddr_i == `OFF_IRQ_CLEAR) begin
      next_irq_status = irq_status & ~pwdata_i[`EV_WIDTH-1:0];
    end
    next_irq_status = next_irq_status | ev;
  end

  // Pending messages: set wins over the send clear
  always @* begin
    msi_clr = {MSI_VECTORS{1'b0}};
    if (state == ST_IDLE && intx_want == intx_sent) begin
      msi_clr = pick_hot;
    end
    next_msi_pend = (msi_pend & ~msi_clr) | (msi_rise & {MSI_VECTORS{msi_enabled_o}});
    if (flr_go) begin
      next_msi_pend = {MSI_VECTORS{1'b0}};
    end
  end

  // APB handshake: one wait-free access phase
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= setup;
      pslverr_o <= setup & ~hit;
      if (setup && !pwrite_i) begin
        prdata_o <= rd_mux;
      end
    end
  end

  // Software-written configuration state
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_reg_o <= 6'h00;
      dev_ctrl2_o <= 5'h00;
      multi_msg_grant_o <= 3'h0;
      msi_enabled_o <= 1'b0;
      msi_addr <= 32'h00000000;
      msi_data <= 16'h0000;
      pwr_state_out_o <= 2'h0;
      pme_allowed_o <= 1'b0;
      pme_status <= 1'b0;
      initiate_flr_o <= 1'b0;
      irq_enable <= {`EV_WIDTH{1'b0}};
      irq_status <= {`EV_WIDTH{1'b0}};
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_status <= next_irq_status;
      irq_o <= |(next_irq_status & irq_enable);
      if (flr_go) begin
        // Function reset returns command, device control 2, message control, power state and power event enable to defaults
        initiate_flr_o <= 1'b0;
        cmd_reg_o <= 6'h00;
        dev_ctrl2_o <= 5'h00;
        multi_msg_grant_o <= 3'h0;
        msi_enabled_o <= 1'b0;
        pwr_state_out_o <= 2'h0;
        pme_allowed_o <= 1'b0;
        // An event in the reset cycle is not lost
        pme_status <= misc_rise[`MISC_PME];
      end else begin
        if (wr_en) begin
          case (paddr_i)
            `OFF_CMD: cmd_reg_o <= pwdata_i[5:0];
            `OFF_DEVCTL2: dev_ctrl2_o <= pwdata_i[4:0];
            `OFF_MSI_CTRL: begin
              msi_enabled_o <= pwdata_i[`MSI_EN_BIT];
              // Only up to eight messages exist, so larger grants clamp
              if (pwdata_i[`MSI_GRANT_LSB+2:`MSI_GRANT_LSB] > `MSI_GRANT_MAX) begin
                multi_msg_grant_o <= `MSI_GRANT_MAX;
              end else begin
                multi_msg_grant_o <= pwdata_i[`MSI_GRANT_LSB+2:`MSI_GRANT_LSB];
              end
            end
            `OFF_MSI_ADDR: msi_addr <= pwdata_i;
            `OFF_MSI_DATA: msi_data <= pwdata_i[15:0];
            `OFF_PM: begin
              pwr_state_out_o <= pwdata_i[1:0];
              pme_allowed_o <= pwdata_i[`PM_PME_EN_BIT];
            end
            `OFF_FLR: begin
              if (pwdata_i[`FLR_START_BIT]) begin
                initiate_flr_o <= 1'b1;
              end
            end
            `OFF_IRQ_ENABLE: irq_enable <= pwdata_i[`EV_WIDTH-1:0];
            default: irq_enable <= irq_enable;
          endcase
        end
        // Write one clears the event status, a new event wins
        if (misc_rise[`MISC_PME]) begin
          pme_status <= 1'b1;
        end else if (wr_en && paddr_i == `OFF_PM && pwdata_i[`PM_PME_STATUS_BIT]) begin
          pme_status <= 1'b0;
        end
      end
    end
  end

  // Legacy interrupt tracking
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_status <= 1'b0;
      intx_want <= 1'b0;
    end else if (ce_i) begin
      if (!msi_enabled_o) begin
        if (misc_fall[`MISC_LEGACY]) begin
          int_status <= 1'b1;
          if (!cmd_reg_o[`CMD_INT_DISABLE]) begin
            intx_want <= 1'b1;
          end
        end else if (misc_rise[`MISC_LEGACY]) begin
          int_status <= 1'b0;
          // Deassert still goes out once disabled, matching the user OR trick
          intx_want <= 1'b0;
        end
      end
    end
  end

  // Message issue; a reverted legacy level before issue sends nothing
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      msi_pend <= {MSI_VECTORS{1'b0}};
      intx_sent <= 1'b0;
      tlp_req_o <= 1'b0;
      tlp_kind_o <= `KIND_MWR;
      tlp_addr_o <= 32'h00000000;
      tlp_data_o <= 16'h0000;
    end else if (ce_i) begin
      msi_pend <= next_msi_pend;
      case (state)
        ST_IDLE: begin
          if (intx_want != intx_sent) begin
            intx_sent <= intx_want;
            tlp_kind_o <= intx_want ? `KIND_ASSERT : `KIND_DEASSERT;
            tlp_req_o <= 1'b1;
            state <= ST_SEND;
          end else if (|msi_pend) begin
            tlp_kind_o <= `KIND_MWR;
            tlp_addr_o <= msi_addr;
            tlp_data_o <= (msi_data & ~vec_mask) | ({13'h0000, pick_idx} & vec_mask);
            tlp_req_o <= 1'b1;
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tlp_ack_i) begin
            tlp_req_o <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          tlp_req_o <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Configuration completions and identity capture
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_cpl_valid_o <= 1'b0;
      cfg_cpl_retry_o <= 1'b0;
      maker_code_o <= DEF_MAKER;
      part_code_o <= DEF_PART;
      revision_code_o <= DEF_REVISION;
      class_code_o <= DEF_CLASS;
      subsystem_maker_code_o <= DEF_SUB_MAKER;
      subsystem_part_code_o <= DEF_SUB_PART;
    end else if (ce_i) begin
      cfg_cpl_valid_o <= cfg_req_i;
      cfg_cpl_retry_o <= cfg_req_i & ~id_loaded;
      // Vectors are taken the cycle after the edge is seen, so hold them one clock more
      if (misc_rise[`MISC_IDLOAD] && IDENTITY_PORT_OPTION != 0) begin
        maker_code_o <= maker_code_in_i;
        part_code_o <= part_code_in_i;
        revision_code_o <= revision_code_in_i;
        class_code_o <= class_code_in_i;
        subsystem_maker_code_o <= subsystem_maker_code_in_i;
        subsystem_part_code_o <= subsystem_part_code_in_i;
      end
    end
  end
endmodule

// ===== hw/sideband_defines.vh
// Operation
// - Rising edge on message request bit n issues memory write for message n+1
// - Function reset initiate output asserts when a function reset is to run
// - Low five bits of device control 2 presented continuously
// - Three-bit output shows granted interrupt message count
// - Message interrupts enabled: enabled output high, legacy request ignored
// - Power event input sets power management event status bit
// - Power event allowed output follows power event enable bit
// - Power state output: 00 D0, 01 D1, 10 D2, 11 D3
// - Identity load low: every configuration request gets retry completion
// - Identity load high: configuration requests get successful completions
// - Identity load rising edge captures all identity vectors into registers
// - Identity load and vectors used only with identity port option
// - Legacy falling edge sends assert and sets status; rising sends deassert, clears
// - Command bit 5 suppresses legacy assert messages (a pending deassert still goes out), status still operates
`ifndef SIDEBAND_DEFINES_VH
`define SIDEBAND_DEFINES_VH

`define OFF_CMD 8'h00
`define OFF_DEVCTL2 8'h04
`define OFF_MSI_CTRL 8'h08
`define OFF_MSI_ADDR 8'h0c
`define OFF_MSI_DATA 8'h10
`define OFF_PM 8'h14
`define OFF_FLR 8'h18
`define OFF_ID0 8'h1c
`define OFF_ID1 8'h20
`define OFF_ID2 8'h24
`define OFF_SIDE_STAT 8'h28
`define OFF_IRQ_STATUS 8'h2c
`define OFF_IRQ_CLEAR 8'h30
`define OFF_IRQ_ENABLE 8'h34

`define CMD_INT_DISABLE 5
`define MSI_EN_BIT 0
`define MSI_GRANT_LSB 1
`define MSI_GRANT_MAX 3'h3
`define PM_PME_EN_BIT 2
`define PM_PME_STATUS_BIT 3
`define FLR_START_BIT 0

`define EV_MSI_SENT 0
`define EV_INTX_SENT 1
`define EV_PME 2
`define EV_FLR_DONE 3
`define EV_ID_LOADED 4
`define EV_RETRY 5
`define EV_WIDTH 6

`define KIND_MWR 2'h0
`define KIND_ASSERT 2'h1
`define KIND_DEASSERT 2'h2

`define MISC_LEGACY 3
`define MISC_IDLOAD 2
`define MISC_FLR_RDY 1
`define MISC_PME 0
`define MISC_RST_VAL 4'h8

`endif

// ===== hw/edge_detect.v
module edge_detect #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // System
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Signals
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);
  reg [W-1:0] prev;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= RST_VAL;
      prev <= RST_VAL;
    end else if (ce_i) begin
      q_o <= d_i;
      prev <= q_o;
    end
  end

  assign rise_o = q_o & ~prev;
  assign fall_o = ~q_o & prev;
endmodule

// ===== hw/prio_pick.v
module prio_pick #(
  parameter N = 8,
  parameter IW = 3
) (
  // Requests
  input wire [N-1:0] req_i,
  // Choice
  output reg [N-1:0] onehot_o,
  output reg [IW-1:0] idx_o
);
  integer i;

  // Lowest index wins, so message 1 is never starved by higher ones
  always @* begin
    onehot_o = {N{1'b0}};
    idx_o = {IW{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req_i[i]) begin
        onehot_o = {N{1'b0}};
        onehot_o[i] = 1'b1;
        idx_o = i[IW-1:0];
      end
    end
  end
endmodule

// ===== test/sideband_ctrl_assertions.sv
module sideband_ctrl_assertions #(
  parameter MSI_VECTORS = 8
) (
  // System and bus
  input wire clk_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire pready_o,
  // Interrupts and messages
  input wire [MSI_VECTORS-1:0] msi_req_i,
  input wire legacy_int_n_i,
  input wire tlp_req_o,
  input wire [1:0] tlp_kind_o,
  input wire [15:0] tlp_data_o,
  input wire tlp_ack_i,
  // Config, reset, mirrors
  input wire cfg_req_i,
  input wire cfg_cpl_valid_o,
  input wire cfg_cpl_retry_o,
  input wire flr_rdy_i,
  input wire initiate_flr_o,
  input wire [5:0] cmd_reg_o,
  input wire [4:0] dev_ctrl2_o,
  input wire [2:0] multi_msg_grant_o,
  input wire msi_enabled_o,
  input wire pme_allowed_o,
  input wire [1:0] pwr_state_out_o,
  input wire identity_load_strobe_i,
  input wire [15:0] maker_code_in_i,
  input wire [15:0] maker_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [31:0] last_wdata;
  wire wr_done = psel_i && penable_i && pready_o && pwrite_i;
  wire [2:0] grant_cap = last_wdata[3:1] > 3'h3 ? 3'h3 : last_wdata[3:1];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Kept only on writes so a later bus cycle cannot hide a stale mirror
  always @(posedge clk_i) begin
    if (wr_done)
      last_wdata <= pwdata_i;
  end

  devctl_mirror_a: assert property (wr_done && paddr_i == 8'h04 |-> ##2 dev_ctrl2_o == last_wdata[4:0])
    else $error("device control 2 mirror wrong");
  pm_mirror_a: assert property (
    wr_done && paddr_i == 8'h14 |-> ##2 {pme_allowed_o, pwr_state_out_o} == last_wdata[2:0])
    else $error("power mirror wrong");
  msi_mirror_a: assert property (
    wr_done && paddr_i == 8'h08 |-> ##2 msi_enabled_o == last_wdata[0] && multi_msg_grant_o == grant_cap)
    else $error("message control mirror wrong");
  retry_unloaded_a: assert property (
    !identity_load_strobe_i [*3] ##0 cfg_req_i |=> cfg_cpl_valid_o && cfg_cpl_retry_o)
    else $error("retry completion missing");
  success_loaded_a: assert property (
    identity_load_strobe_i [*3] ##0 cfg_req_i |=> cfg_cpl_valid_o && !cfg_cpl_retry_o)
    else $error("success completion missing");
  cpl_cause_a: assert property (cfg_cpl_valid_o |-> $past(cfg_req_i))
    else $error("completion without request");
  msg_hold_a: assert property (
    tlp_req_o && !tlp_ack_i && !$past(tlp_ack_i) |=> tlp_req_o && $stable(tlp_data_o))
    else $error("message request not held");
  msi_issue_a: assert property (
    msi_enabled_o && $rose(msi_req_i[0]) |-> ##[2:40] tlp_req_o && tlp_kind_o == 2'h0)
    else $error("message write not issued");
  legacy_msg_a: assert property (
    !msi_enabled_o && !cmd_reg_o[5] && $fell(legacy_int_n_i) |-> ##[2:40] tlp_kind_o == 2'h1)
    else $error("assert message not issued");
  flr_hold_a: assert property (initiate_flr_o && !flr_rdy_i && !$past(flr_rdy_i) |=> initiate_flr_o)
    else $error("reset request dropped early");
  id_capture_a: assert property (
    $rose(identity_load_strobe_i) ##0 $stable(maker_code_in_i) [*5] |-> maker_code_o == maker_code_in_i)
    else $error("identity not captured");
endmodule

bind sideband_ctrl sideband_ctrl_assertions #(.MSI_VECTORS(MSI_VECTORS)) chk_u (.clk_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .msi_req_i, .legacy_int_n_i, .tlp_req_o, .tlp_kind_o, .tlp_data_o,
  .tlp_ack_i, .cfg_req_i, .cfg_cpl_valid_o, .cfg_cpl_retry_o, .flr_rdy_i, .initiate_flr_o, .cmd_reg_o, .dev_ctrl2_o,
  .multi_msg_grant_o, .msi_enabled_o, .pme_allowed_o, .pwr_state_out_o, .identity_load_strobe_i, .maker_code_in_i,
  .maker_code_o);

// ===== test/user_logic_model.sv
module user_logic_model (
  // System
  input wire clk_i,
  input wire rst_i,
  // Bench controls
  input wire int_req_n_i,
  input wire or_en_i,
  input wire [3:0] stall_i,
  // Core side
  input wire tlp_req_i,
  input wire initiate_i,
  input wire int_disable_i,
  output reg tlp_ack_o,
  output reg flr_rdy_o,
  output wire legacy_int_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] wait_cnt;
  reg [1:0] guard;
  reg init_seen;

  // Disable bit forces the line idle, so a held request still gets its deassert
  assign legacy_int_n_o = int_req_n_i | (or_en_i & int_disable_i);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tlp_ack_o <= 1'b0;
      flr_rdy_o <= 1'b0;
      init_seen <= 1'b0;
      wait_cnt <= 4'h0;
      guard <= 2'h0;
    end else begin
      tlp_ack_o <= 1'b0;
      init_seen <= initiate_i;
      flr_rdy_o <= initiate_i & init_seen;
      if (guard != 2'h0) begin
        guard <= guard - 2'h1;
      end else if (tlp_req_i && wait_cnt < stall_i) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else if (tlp_req_i) begin
        // Guard stops one request being acknowledged twice while it drops
        tlp_ack_o <= 1'b1;
        wait_cnt <= 4'h0;
        guard <= 2'h2;
      end
    end
  end
endmodule

// ===== test/sideband_ctrl_test.sv
module sideband_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic cfg_req_i = 1'b0, pme_event_i = 1'b0, identity_load_strobe_i = 1'b0, int_req_n = 1'b1, or_en = 1'b1, slv;
  logic [7:0] paddr_i = 8'h00, msi_req_i = 8'h00, revision_code_in_i = 8'h00, revision_code_o;
  logic [31:0] pwdata_i = 32'h0, rd, madr, mdat, prdata_o, tlp_addr_o;
  logic [15:0] maker_code_in_i = 16'h0, part_code_in_i = 16'h0;
  logic [15:0] subsystem_maker_code_in_i = 16'h0, subsystem_part_code_in_i = 16'h0;
  logic [23:0] class_code_in_i = 24'h0, class_code_o;
  logic [3:0] stall = 4'h0;
  logic pready_o, pslverr_o, irq_o, tlp_req_o, tlp_ack_i, cfg_cpl_valid_o, cfg_cpl_retry_o, flr_rdy_i;
  logic initiate_flr_o, msi_enabled_o, pme_allowed_o, legacy_int_n_i;
  logic [1:0] tlp_kind_o, pwr_state_out_o;
  logic [15:0] tlp_data_o, maker_code_o, part_code_o, subsystem_maker_code_o, subsystem_part_code_o;
  logic [5:0] cmd_reg_o;
  logic [4:0] dev_ctrl2_o;
  logic [2:0] multi_msg_grant_o;
  logic [17:0] expq[$];
  int errors = 0, samples_checked = 0, seed = 32'h5639;

  sideband_ctrl dut_u (.clk_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .irq_o, .msi_req_i, .legacy_int_n_i, .tlp_req_o, .tlp_kind_o, .tlp_addr_o, .tlp_data_o,
    .tlp_ack_i, .cfg_req_i, .cfg_cpl_valid_o, .cfg_cpl_retry_o, .flr_rdy_i, .initiate_flr_o, .cmd_reg_o,
    .dev_ctrl2_o, .multi_msg_grant_o, .msi_enabled_o, .pme_allowed_o, .pwr_state_out_o, .pme_event_i,
    .identity_load_strobe_i, .maker_code_in_i, .part_code_in_i, .revision_code_in_i, .class_code_in_i,
    .subsystem_maker_code_in_i, .subsystem_part_code_in_i, .maker_code_o, .part_code_o, .revision_code_o,
    .class_code_o, .subsystem_maker_code_o, .subsystem_part_code_o);
  user_logic_model user_u (.clk_i, .rst_i, .int_req_n_i(int_req_n), .or_en_i(or_en), .stall_i(stall),
    .tlp_req_i(tlp_req_o), .initiate_i(initiate_flr_o), .int_disable_i(cmd_reg_o[5]), .tlp_ack_o(tlp_ack_i),
    .flr_rdy_o(flr_rdy_i), .legacy_int_n_o(legacy_int_n_i));

  always #4 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    // No wait limit here; a silent slave is caught by the watchdog
    while (pready_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata_o;
    slv = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic cfg(input logic retry);
    @(posedge clk_i);
    cfg_req_i <= 1'b1;
    @(posedge clk_i);
    cfg_req_i <= 1'b0;
    @(posedge clk_i);
    chk({cfg_cpl_valid_o, cfg_cpl_retry_o}, {1'b1, retry});
  endtask

  // Every accepted message must be the oldest one still expected
  always @(posedge clk_i) begin
    if (tlp_req_o === 1'b1 && tlp_ack_i === 1'b1) begin
      chk({tlp_kind_o, tlp_kind_o == 2'h0 ? tlp_data_o : 16'h0},
        expq.size() ? expq.pop_front() : 32'hffff);
      if (tlp_kind_o == 2'h0)
        chk(tlp_addr_o, madr);
    end
  end

  initial begin
    #100us;
    errors++;
    print_verdict;
  end

  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 56; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 8'h3c, $random(seed));
    chk(slv, 1'b1);
    r = $random(seed);
    apb(1'b1, 8'h04, r);
    idle(2);
    chk(dev_ctrl2_o, r[4:0]);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 8'h14, s);
      idle(2);
      chk({pme_allowed_o, pwr_state_out_o}, s[2:0]);
    end
    pme_event_i <= 1'b1;
    idle(6);
    chk(irq_o, 1'b0);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd[3], 1'b1);
    apb(1'b1, 8'h34, 32'h4);
    idle(3);
    chk(irq_o, 1'b1);
    apb(1'b1, 8'h30, 32'h4);
    idle(3);
    chk(irq_o, 1'b0);
    madr = $random(seed);
    mdat = $random(seed);
    apb(1'b1, 8'h0c, madr);
    apb(1'b1, 8'h10, mdat);
    for (int g = 0; g < 8; g++) begin
      apb(1'b1, 8'h08, {g[2:0], 1'b1});
      idle(2);
      chk({msi_enabled_o, multi_msg_grant_o}, {1'b1, g > 3 ? 3'h3 : g[2:0]});
    end
    stall <= 4'h5;
    r = $random(seed) | 1;
    for (int n = 0; n < 8; n++) begin
      if (r[n])
        expq.push_back({2'h0, mdat[15:3], n[2:0]});
    end
    msi_req_i <= r[7:0];
    int_req_n <= 1'b0;
    idle(100);
    int_req_n <= 1'b1;
    msi_req_i <= 8'h00;
    apb(1'b1, 8'h08, 32'h0);
    msi_req_i <= 8'h02;
    idle(20);
    stall <= 4'h0;
    int_req_n <= 1'b0;
    expq.push_back({2'h1, 16'h0});
    idle(12);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd[0], 1'b1);
    expq.push_back({2'h2, 16'h0});
    apb(1'b1, 8'h00, 32'h20);
    idle(12);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd[0], 1'b0);
    or_en <= 1'b0;
    idle(12);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd[0], 1'b1);
    int_req_n <= 1'b1;
    idle(12);
    chk(expq.size(), 32'h0);
    cfg(1'b1);
    {maker_code_in_i, part_code_in_i} <= $random(seed);
    {revision_code_in_i, class_code_in_i} <= $random(seed);
    {subsystem_maker_code_in_i, subsystem_part_code_in_i} <= $random(seed);
    // Vectors settle a cycle before the strobe rises
    idle(1);
    identity_load_strobe_i <= 1'b1;
    idle(6);
    chk({maker_code_o, part_code_o}, {maker_code_in_i, part_code_in_i});
    chk({revision_code_o, class_code_o}, {revision_code_in_i, class_code_in_i});
    chk({subsystem_maker_code_o, subsystem_part_code_o},
      {subsystem_maker_code_in_i, subsystem_part_code_in_i});
    r = {maker_code_in_i, part_code_in_i};
    {maker_code_in_i, part_code_in_i} <= $random(seed);
    cfg(1'b0);
    chk({maker_code_o, part_code_o}, r);
    apb(1'b1, 8'h18, 32'h1);
    idle(2);
    chk(initiate_flr_o, 1'b1);
    idle(10);
    chk({initiate_flr_o, cmd_reg_o, dev_ctrl2_o, msi_enabled_o, pwr_state_out_o}, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    chk(rd[3], 1'b1);
    print_verdict;
  end
endmodule
